// ===== mrb_map.svh
`ifndef MRB_MAP_SVH
`define MRB_MAP_SVH

// register indices
`define MRB_IDX_BCR 5'h00
`define MRB_IDX_BSR 5'h01
`define MRB_IDX_MMDC 5'h0D
`define MRB_IDX_MMDD 5'h0E
`define MRB_IDX_MODE 5'h11
`define MRB_IDX_SPEC 5'h12
`define MRB_IDX_TDRP 5'h18
`define MRB_IDX_SYMC 5'h1A
`define MRB_IDX_FLT 5'h1B
`define MRB_IDX_FCNT 5'h1C
`define MRB_IDX_EVT 5'h1D
`define MRB_IDX_VND 5'h1F

// basic control fields
`define MRB_BCR_SRST 15
`define MRB_BCR_LOOP 14
`define MRB_BCR_SPEED 13
`define MRB_BCR_ANEN 12
`define MRB_BCR_PDN 11
`define MRB_BCR_ISO 10
`define MRB_BCR_ANRST 9
`define MRB_BCR_DPLX 8

// basic status fields
`define MRB_BSR_ABIL 5'h0F
`define MRB_BSR_ANDONE 5
`define MRB_BSR_RFLT 4
`define MRB_BSR_LINK 2
`define MRB_BSR_JAB 1
`define MRB_BSR_EXTCAP 0

// strap bit positions
`define MRB_STRAP_SPEED 0
`define MRB_STRAP_DPLX 1
`define MRB_STRAP_ANEN 2

// mmd access
`define MRB_MMDC_FN_HI 15
`define MRB_MMDC_FN_LO 14
`define MRB_MMD_DEV 5'h03
`define MRB_MMD_DEPTH 16

// mode control fields
`define MRB_MODE_FARLB 9
`define MRB_MODE_RDY 1
`define MRB_MODE_ENERGY 0

// special modes reset values
`define MRB_SPEC_MODE_RST 3'h7
`define MRB_SPEC_PHYAD_RST 5'h00

// vendor register fields
`define MRB_VND_SEEN 12
`define MRB_VND_HI 6
`define MRB_VND_LO 2

// timing
`define MRB_CLK_NS 20
`define MRB_ANRST_NS 80
`define MRB_ANRST_CYC ((`MRB_ANRST_NS + `MRB_CLK_NS - 1) / `MRB_CLK_NS)
`define MRB_SSREC_NS 160
`define MRB_SSREC_CYC ((`MRB_SSREC_NS + `MRB_CLK_NS - 1) / `MRB_CLK_NS)
`define MRB_STRAP_LD 2'h2
`define MRB_STRAP_DONE 2'h3

`endif

// ===== mrb_pkg.sv
package mrb_pkg;
  typedef logic [15:0] mrb_word_t;
  typedef logic [4:0] mrb_idx_t;
  typedef enum logic [1:0] {
    MRB_FN_ADDR = 2'h0,
    MRB_FN_DATA = 2'h1,
    MRB_FN_INC_RW = 2'h2,
    MRB_FN_INC_W = 2'h3
  } mrb_mmd_fn_t;
endpackage

// ===== mrb_mmd_mem.sv
`timescale 1ns/1ps
module mrb_mmd_mem (
  // clock
  input wire logic clk_in,
  // write port
  input wire logic we_in,
  input wire logic [3:0] waddr_in,
  input wire mrb_pkg::mrb_word_t wdata_in,
  // read port
  input wire logic [3:0] raddr_in,
  output mrb_pkg::mrb_word_t rdata_out
);
  import mrb_pkg::*;

  // contents are not reset: they model storage, not control state
  mrb_word_t mem_r [0:15];

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_r[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    rdata_out <= mem_r[raddr_in];
  end
endmodule

// ===== mrb_mgmt_regs.sv
// Overview of operation
// RULE1: read-only fields ignore every write and keep their value.
// RULE2: write-only fields may read back anything; here they read zero.
// RULE3: write-one-to-clear flags clear on a written one, keep on a zero.
// RULE4: write-anything-to-clear fields clear on any write to them.
// RULE5: read-to-clear fields clear once returned and ignore writes.
// RULE6: latch-low and latch-high bits clear when their register is read.
// RULE7: self-clearing bits drop by themselves, zero writes do nothing.
// RULE8: self-setting bits rise by themselves, one writes do nothing.
// RULE9: a sticky high status bit holds until read, then follows the input.
// RULE10: soft-reset-immune fields keep value on soft reset, others default.
// RULE11: the controller writes zero to reserved bits and ignores them.
// RULE12: read-write fields read back, read-write-any-clear clear on write.
// RULE13: registers are selected by their standard decimal index.
// RULE14: extended device registers are reached only via two access regs.
// RULE15: control bit 15 is a self-clearing soft reset taken alone.
// RULE16: the index is five bits and unimplemented indices read zero.
`timescale 1ns/1ps
`include "mrb_map.svh"
module mrb_mgmt_regs (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  // management access
  input wire logic REQ_IN,
  input wire logic REQ_WR_IN,
  input wire mrb_pkg::mrb_idx_t REQ_IDX_IN,
  input wire mrb_pkg::mrb_word_t REQ_WDATA_IN,
  output logic ACK_OUT,
  output mrb_pkg::mrb_word_t RDATA_OUT,
  // straps
  input wire logic [2:0] MODE_STRAP_IN,
  // status conditions
  input wire logic LINK_UP_IN,
  input wire logic JABBER_IN,
  input wire logic REM_FAULT_IN,
  input wire logic AN_DONE_IN,
  input wire logic ENERGY_IN,
  input wire logic SYM_ERR_IN,
  input wire logic [3:0] FAULT_IN,
  input wire logic [7:0] EVENT_IN,
  // control outputs
  output logic SOFT_RST_OUT,
  output logic LOOPBACK_OUT,
  output logic SPEED_OUT,
  output logic AN_EN_OUT,
  output logic PWRDN_OUT,
  output logic ISOLATE_OUT,
  output logic DUPLEX_OUT,
  output logic AN_RESTART_OUT,
  output logic FAR_LOOP_OUT,
  output logic DIAG_READY_OUT,
  output logic [2:0] MODE_OUT,
  output logic [4:0] PHY_ADDR_OUT,
  output mrb_pkg::mrb_word_t TDR_PAT_OUT,
  output logic [4:0] VENDOR_CTL_OUT
);
  import mrb_pkg::*;

  function automatic logic acc(input logic en, input mrb_idx_t a,
                               input mrb_idx_t b);
    return en & (a == b);
  endfunction

  logic busy_r, pend_wr_r, take, wr_now, rd_done, srst_r;
  mrb_idx_t pend_idx_r;
  logic [2:0] strap_s1_r, strap_s2_r, strap_q_r, strap_now;
  logic [1:0] strap_cnt_r;
  logic ld_dflt;
  logic [3:0] anrst_cnt_r, ss_cnt_r;
  logic link_lat_r, jab_lat_r, rflt_lat_r, an_seen_r;
  logic [1:0] mmd_fn_r;
  logic [4:0] mmd_dev_r;
  mrb_word_t mmd_addr_r, mem_q, rd_val, sym_cnt_r;
  logic [3:0] flt_flag_r;
  logic [7:0] fcnt_r, evt_r;
  logic mmd_data, mmd_ok, mem_we, wr_bcr, rd_bsr, rd_mmdd;

  // one request in flight; answer two cycles after it is taken
  assign take = REQ_IN & ~busy_r;
  assign wr_now = take & REQ_WR_IN;
  assign rd_done = busy_r & ~pend_wr_r;
  // a soft reset write carries nothing else
  assign wr_bcr = acc(wr_now, REQ_IDX_IN, `MRB_IDX_BCR); // RULE13
  assign rd_bsr = acc(rd_done, pend_idx_r, `MRB_IDX_BSR);
  assign rd_mmdd = acc(rd_done, pend_idx_r, `MRB_IDX_MMDD);

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      busy_r <= 1'b0;
      pend_wr_r <= 1'b0;
      pend_idx_r <= 5'h00;
      ACK_OUT <= 1'b0;
    end else begin
      busy_r <= take;
      if (take) begin
        pend_wr_r <= REQ_WR_IN;
        pend_idx_r <= REQ_IDX_IN; // RULE16
      end
      ACK_OUT <= busy_r;
    end
  end

  // strap pins are asynchronous levels, so two flops before use
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      strap_s1_r <= 3'h0;
      strap_s2_r <= 3'h0;
      strap_cnt_r <= 2'h0;
      strap_q_r <= 3'h0;
    end else begin
      strap_s1_r <= MODE_STRAP_IN;
      strap_s2_r <= strap_s1_r;
      if (strap_cnt_r != `MRB_STRAP_DONE) begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
      end
      if (strap_cnt_r == `MRB_STRAP_LD) begin
        strap_q_r <= strap_s2_r;
      end
    end
  end

  assign strap_now = (strap_cnt_r == `MRB_STRAP_LD) ? strap_s2_r : strap_q_r;
  assign ld_dflt = srst_r | (strap_cnt_r == `MRB_STRAP_LD);

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      srst_r <= 1'b0;
    end else begin
      srst_r <= wr_bcr & REQ_WDATA_IN[`MRB_BCR_SRST]; // RULE15 RULE7
    end
  end

  // basic control fields; strap-derived defaults reload on soft reset
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      LOOPBACK_OUT <= 1'b0;
      SPEED_OUT <= 1'b0;
      AN_EN_OUT <= 1'b0;
      PWRDN_OUT <= 1'b0;
      ISOLATE_OUT <= 1'b0;
      DUPLEX_OUT <= 1'b0;
    end else if (ld_dflt) begin
      LOOPBACK_OUT <= 1'b0; // RULE10
      SPEED_OUT <= strap_now[`MRB_STRAP_SPEED];
      AN_EN_OUT <= strap_now[`MRB_STRAP_ANEN];
      PWRDN_OUT <= 1'b0;
      ISOLATE_OUT <= 1'b0;
      DUPLEX_OUT <= strap_now[`MRB_STRAP_DPLX];
    end else if (wr_bcr && !REQ_WDATA_IN[`MRB_BCR_SRST]) begin
      LOOPBACK_OUT <= REQ_WDATA_IN[`MRB_BCR_LOOP]; // RULE12
      SPEED_OUT <= REQ_WDATA_IN[`MRB_BCR_SPEED];
      AN_EN_OUT <= REQ_WDATA_IN[`MRB_BCR_ANEN];
      PWRDN_OUT <= REQ_WDATA_IN[`MRB_BCR_PDN];
      ISOLATE_OUT <= REQ_WDATA_IN[`MRB_BCR_ISO];
      DUPLEX_OUT <= REQ_WDATA_IN[`MRB_BCR_DPLX];
    end
  end

  // restart pulse holds a fixed time then clears itself
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      AN_RESTART_OUT <= 1'b0;
      anrst_cnt_r <= 4'h0;
    end else if (srst_r) begin
      AN_RESTART_OUT <= 1'b0;
      anrst_cnt_r <= 4'h0;
    end else if (wr_bcr && !REQ_WDATA_IN[`MRB_BCR_SRST] &&
                 REQ_WDATA_IN[`MRB_BCR_ANRST]) begin
      AN_RESTART_OUT <= 1'b1;
      anrst_cnt_r <= 4'h0;
    end else if (AN_RESTART_OUT) begin
      anrst_cnt_r <= anrst_cnt_r + 4'h1;
      if (anrst_cnt_r == 4'(`MRB_ANRST_CYC - 1)) begin
        AN_RESTART_OUT <= 1'b0; // RULE7
      end
    end
  end

  // link is latch-low, jabber and remote fault latch-high
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      link_lat_r <= 1'b0;
      jab_lat_r <= 1'b0;
      rflt_lat_r <= 1'b0;
    end else if (srst_r) begin
      link_lat_r <= LINK_UP_IN;
      jab_lat_r <= JABBER_IN;
      rflt_lat_r <= REM_FAULT_IN;
    end else begin
      link_lat_r <= (rd_bsr | link_lat_r) & LINK_UP_IN; // RULE6
      jab_lat_r <= (jab_lat_r & ~rd_bsr) | JABBER_IN; // RULE6
      rflt_lat_r <= (rflt_lat_r & ~rd_bsr) | REM_FAULT_IN; // RULE9
    end
  end

  // mmd access: indirect path only, no direct index reaches it
  assign mmd_data = (mmd_fn_r != MRB_FN_ADDR);
  assign mmd_ok = (mmd_dev_r == `MRB_MMD_DEV) &&
                  (mmd_addr_r < 16'(`MRB_MMD_DEPTH));
  assign mem_we = acc(wr_now, REQ_IDX_IN, `MRB_IDX_MMDD) & mmd_data &
                  mmd_ok; // RULE14

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      mmd_fn_r <= 2'h0;
      mmd_dev_r <= 5'h00;
      mmd_addr_r <= 16'h0000;
    end else if (srst_r) begin
      mmd_fn_r <= 2'h0;
      mmd_dev_r <= 5'h00;
      mmd_addr_r <= 16'h0000;
    end else begin
      if (acc(wr_now, REQ_IDX_IN, `MRB_IDX_MMDC)) begin
        mmd_fn_r <= REQ_WDATA_IN[`MRB_MMDC_FN_HI:`MRB_MMDC_FN_LO];
        mmd_dev_r <= REQ_WDATA_IN[4:0];
      end
      if (acc(wr_now, REQ_IDX_IN, `MRB_IDX_MMDD)) begin
        if (!mmd_data) begin
          mmd_addr_r <= REQ_WDATA_IN; // RULE14
        end else if (mmd_fn_r[1]) begin
          mmd_addr_r <= mmd_addr_r + 16'h0001;
        end
      end else if (rd_mmdd && mmd_fn_r == MRB_FN_INC_RW) begin
        mmd_addr_r <= mmd_addr_r + 16'h0001;
      end
    end
  end

  mrb_mmd_mem u_mem (
    .clk_in(CLK_IN),
    .we_in(mem_we),
    .waddr_in(mmd_addr_r[3:0]),
    .wdata_in(REQ_WDATA_IN),
    .raddr_in(mmd_addr_r[3:0]),
    .rdata_out(mem_q)
  );

  // mode control: far loopback plain, ready bit self-setting
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      FAR_LOOP_OUT <= 1'b0;
      DIAG_READY_OUT <= 1'b1;
      ss_cnt_r <= 4'h0;
    end else if (srst_r) begin
      FAR_LOOP_OUT <= 1'b0;
      DIAG_READY_OUT <= 1'b1;
      ss_cnt_r <= 4'h0;
    end else if (acc(wr_now, REQ_IDX_IN, `MRB_IDX_MODE)) begin
      FAR_LOOP_OUT <= REQ_WDATA_IN[`MRB_MODE_FARLB];
      if (!REQ_WDATA_IN[`MRB_MODE_RDY]) begin
        DIAG_READY_OUT <= 1'b0; // RULE8
        ss_cnt_r <= 4'h0;
      end
    end else if (!DIAG_READY_OUT) begin
      ss_cnt_r <= ss_cnt_r + 4'h1;
      if (ss_cnt_r == 4'(`MRB_SSREC_CYC - 1)) begin
        DIAG_READY_OUT <= 1'b1; // RULE8
      end
    end
  end

  // special modes survive soft reset
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      MODE_OUT <= `MRB_SPEC_MODE_RST;
      PHY_ADDR_OUT <= `MRB_SPEC_PHYAD_RST;
    end else if (acc(wr_now, REQ_IDX_IN, `MRB_IDX_SPEC)) begin
      MODE_OUT <= REQ_WDATA_IN[7:5]; // RULE10
      PHY_ADDR_OUT <= REQ_WDATA_IN[4:0];
    end
  end

  // write-only pattern field and read-write vendor fields
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      TDR_PAT_OUT <= 16'h0000;
      VENDOR_CTL_OUT <= 5'h00;
      an_seen_r <= 1'b0;
    end else if (srst_r) begin
      TDR_PAT_OUT <= 16'h0000;
      VENDOR_CTL_OUT <= 5'h00;
      an_seen_r <= AN_DONE_IN;
    end else begin
      if (acc(wr_now, REQ_IDX_IN, `MRB_IDX_TDRP)) begin
        TDR_PAT_OUT <= REQ_WDATA_IN; // RULE2
      end
      if (acc(wr_now, REQ_IDX_IN, `MRB_IDX_VND)) begin
        VENDOR_CTL_OUT <= REQ_WDATA_IN[`MRB_VND_HI:`MRB_VND_LO]; // RULE12
      end
      // any write clears, a new event in the same cycle wins
      an_seen_r <= (an_seen_r & ~acc(wr_now, REQ_IDX_IN, `MRB_IDX_VND)) |
                   AN_DONE_IN; // RULE12
    end
  end

  // fault flags clear per written one; event wins over clear
  for (genvar g = 0; g < 4; g++) begin : g_flt
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
        flt_flag_r[g] <= 1'b0;
      end else if (srst_r) begin
        flt_flag_r[g] <= FAULT_IN[g];
      end else begin
        flt_flag_r[g] <= (flt_flag_r[g] &
                         ~(acc(wr_now, REQ_IDX_IN, `MRB_IDX_FLT) &
                         REQ_WDATA_IN[g])) | FAULT_IN[g]; // RULE3
      end
    end
  end

  // counters saturate rather than wrap so software never misreads low
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      fcnt_r <= 8'h00;
      sym_cnt_r <= 16'h0000;
      evt_r <= 8'h00;
    end else if (srst_r) begin
      fcnt_r <= 8'h00;
      sym_cnt_r <= 16'h0000;
      evt_r <= EVENT_IN;
    end else begin
      if (acc(wr_now, REQ_IDX_IN, `MRB_IDX_FCNT)) begin
        // a fault in the clearing cycle still counts
        fcnt_r <= {7'h00, |(FAULT_IN & ~flt_flag_r)}; // RULE4
      end else if ((|(FAULT_IN & ~flt_flag_r)) && fcnt_r != 8'hFF) begin
        fcnt_r <= fcnt_r + 8'h01;
      end
      if (acc(rd_done, pend_idx_r, `MRB_IDX_SYMC)) begin
        sym_cnt_r <= {15'h0000, SYM_ERR_IN}; // RULE5
      end else if (SYM_ERR_IN && sym_cnt_r != 16'hFFFF) begin
        sym_cnt_r <= sym_cnt_r + 16'h0001;
      end
      evt_r <= (evt_r & ~{8{acc(rd_done, pend_idx_r, `MRB_IDX_EVT)}}) |
               EVENT_IN; // RULE5
    end
  end

  // read data; reserved and unmapped bits return zero
  always_comb begin
    rd_val = 16'h0000;
    unique case (pend_idx_r)
      `MRB_IDX_BCR: begin
        rd_val[`MRB_BCR_SRST] = srst_r;
        rd_val[`MRB_BCR_LOOP] = LOOPBACK_OUT;
        rd_val[`MRB_BCR_SPEED] = SPEED_OUT;
        rd_val[`MRB_BCR_ANEN] = AN_EN_OUT;
        rd_val[`MRB_BCR_PDN] = PWRDN_OUT;
        rd_val[`MRB_BCR_ISO] = ISOLATE_OUT;
        rd_val[`MRB_BCR_ANRST] = AN_RESTART_OUT; // RULE7
        rd_val[`MRB_BCR_DPLX] = DUPLEX_OUT;
      end
      `MRB_IDX_BSR: begin
        rd_val[15:11] = `MRB_BSR_ABIL; // RULE1
        rd_val[`MRB_BSR_ANDONE] = AN_DONE_IN;
        rd_val[`MRB_BSR_RFLT] = rflt_lat_r;
        rd_val[`MRB_BSR_LINK] = link_lat_r;
        rd_val[`MRB_BSR_JAB] = jab_lat_r;
        rd_val[`MRB_BSR_EXTCAP] = 1'b1;
      end
      `MRB_IDX_MMDC: begin
        rd_val[`MRB_MMDC_FN_HI:`MRB_MMDC_FN_LO] = mmd_fn_r;
        rd_val[4:0] = mmd_dev_r;
      end
      `MRB_IDX_MMDD: begin
        rd_val = !mmd_data ? mmd_addr_r : (mmd_ok ? mem_q : 16'h0000);
      end
      `MRB_IDX_MODE: begin
        rd_val[`MRB_MODE_FARLB] = FAR_LOOP_OUT;
        rd_val[`MRB_MODE_RDY] = DIAG_READY_OUT; // RULE8
        rd_val[`MRB_MODE_ENERGY] = ENERGY_IN;
      end
      `MRB_IDX_SPEC: rd_val[7:0] = {MODE_OUT, PHY_ADDR_OUT};
      `MRB_IDX_SYMC: rd_val = sym_cnt_r;
      `MRB_IDX_FLT: rd_val[3:0] = flt_flag_r;
      `MRB_IDX_FCNT: rd_val[7:0] = fcnt_r;
      `MRB_IDX_EVT: rd_val[7:0] = evt_r;
      `MRB_IDX_VND: begin
        rd_val[`MRB_VND_SEEN] = an_seen_r;
        rd_val[`MRB_VND_HI:`MRB_VND_LO] = VENDOR_CTL_OUT;
      end
      default: rd_val = 16'h0000; // RULE16
    endcase
  end

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      RDATA_OUT <= 16'h0000;
      SOFT_RST_OUT <= 1'b0;
    end else begin
      if (busy_r) begin
        RDATA_OUT <= pend_wr_r ? 16'h0000 : rd_val;
      end
      SOFT_RST_OUT <= srst_r;
    end
  end
endmodule

// ===== mrb_mgmt_regs_chk.sv
`timescale 1ns/1ps
module mrb_mgmt_regs_chk (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  // management access
  input wire logic REQ_IN,
  input wire logic REQ_WR_IN,
  input wire mrb_pkg::mrb_idx_t REQ_IDX_IN,
  input wire mrb_pkg::mrb_word_t REQ_WDATA_IN,
  input wire logic ACK_OUT,
  input wire mrb_pkg::mrb_word_t RDATA_OUT,
  // control outputs
  input wire logic SOFT_RST_OUT,
  input wire logic LOOPBACK_OUT,
  input wire logic AN_RESTART_OUT,
  input wire logic DIAG_READY_OUT,
  input wire logic [4:0] PHY_ADDR_OUT
);
  import mrb_pkg::*;
  logic take;
  logic take_r;
  logic wr0;
  logic unimp;
  // a request right after a take is dropped, so takes never sit adjacent
  assign take = REQ_IN && !take_r;
  assign wr0 = take && REQ_WR_IN && REQ_IDX_IN == 5'h00;
  assign unimp = !(REQ_IDX_IN inside {5'h00, 5'h01, 5'h0D, 5'h0E, 5'h11,
    5'h12, 5'h18, [5'h1A:5'h1D], 5'h1F});
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      take_r <= 1'b0;
    end else begin
      take_r <= take;
    end
  end
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);
  property p_ack_lat;
    take |-> ##2 ACK_OUT;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_pulse;
    ACK_OUT |=> !ACK_OUT;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
  property p_bsr;
    ACK_OUT && $past(take && !REQ_WR_IN && REQ_IDX_IN == 5'h01, 2)
      |-> RDATA_OUT[15:11] == 5'h0F && RDATA_OUT[0];
  endproperty
  a_bsr: assert property (p_bsr) else $error("status fixed bits");
  property p_unimp;
    ACK_OUT && $past(take && unimp, 2) |-> RDATA_OUT == 16'h0000;
  endproperty
  a_unimp: assert property (p_unimp) else $error("empty index");
  property p_srst;
    wr0 && REQ_WDATA_IN[15] |-> ##[2:4] SOFT_RST_OUT;
  endproperty
  a_srst: assert property (p_srst) else $error("no soft reset");
  property p_srst_def;
    SOFT_RST_OUT |-> !LOOPBACK_OUT && !AN_RESTART_OUT;
  endproperty
  a_srst_def: assert property (p_srst_def) else $error("defaults");
  property p_anrst;
    wr0 && !REQ_WDATA_IN[15] && REQ_WDATA_IN[9]
      |=> AN_RESTART_OUT [*4] ##[1:2] !AN_RESTART_OUT;
  endproperty
  a_anrst: assert property (p_anrst) else $error("restart span");
  property p_loop;
    wr0 && !REQ_WDATA_IN[15] |=> LOOPBACK_OUT == $past(REQ_WDATA_IN[14]);
  endproperty
  a_loop: assert property (p_loop) else $error("loopback");
  property p_diag;
    take && REQ_WR_IN && REQ_IDX_IN == 5'h11 && !REQ_WDATA_IN[1]
      |=> !DIAG_READY_OUT ##[6:9] DIAG_READY_OUT;
  endproperty
  a_diag: assert property (p_diag) else $error("self set");
  property p_phy;
    take && REQ_WR_IN && REQ_IDX_IN == 5'h12
      |=> PHY_ADDR_OUT == $past(REQ_WDATA_IN[4:0]);
  endproperty
  a_phy: assert property (p_phy) else $error("phy address");
  c_srst: cover property (wr0 && REQ_WDATA_IN[15]);
  c_unimp: cover property (ACK_OUT && $past(take && unimp, 2));
  c_anrst: cover property ($fell(AN_RESTART_OUT));
endmodule
bind mrb_mgmt_regs mrb_mgmt_regs_chk u_chk (.*);

// ===== mrb_smc.sv
`timescale 1ns/1ps
module mrb_smc (
  // answer from the block
  input wire logic clk_in,
  input wire logic ack_in,
  input wire mrb_pkg::mrb_word_t rdata_in,
  // request to the block
  output logic req_out,
  output logic wr_out,
  output mrb_pkg::mrb_idx_t idx_out,
  output mrb_pkg::mrb_word_t wdata_out
);
  import mrb_pkg::*;
  initial begin
    req_out = 1'b0;
    wr_out = 1'b0;
    idx_out = 5'h00;
    wdata_out = 16'h0000;
  end
  // one word per transfer, selected by its five bit index
  task automatic xfer(input logic w, input mrb_idx_t i, input mrb_word_t d,
                      output mrb_word_t r, output logic ok);
    int n;
    n = 0;
    @(negedge clk_in);
    req_out = 1'b1;
    wr_out = w;
    idx_out = i;
    wdata_out = d;
    @(posedge clk_in);
    @(negedge clk_in);
    // released lines flip so a stale word is never mistaken for data
    req_out = 1'b0;
    wr_out = ~w;
    idx_out = ~i;
    wdata_out = ~d;
    while (ack_in !== 1'b1 && n < 4) begin
      @(negedge clk_in);
      n++;
    end
    r = rdata_in;
    ok = (n < 4);
  endtask
endmodule

// ===== mrb_mgmt_regs_tb.sv
`timescale 1ns/1ps
module mrb_mgmt_regs_tb;
  import mrb_pkg::*;
  logic clk = 0, nrst = 0, req, wr, ack, srst, loopb, spd, anen, dpx, anrs;
  logic farl, diag, link = 1, jab = 0, rflt = 0, andn = 0, nrg = 0, sym = 0;
  logic [3:0] flt = 4'h0;
  logic [7:0] evt = 8'h00;
  logic [2:0] strap = 3'h5;
  logic [2:0] mode;
  logic pdn, iso;
  logic [4:0] phya, vctl;
  mrb_idx_t idx;
  mrb_word_t wd, rdat, tdr;
  int bad_count = 0, compares = 0;
  always #10 clk = ~clk;
  mrb_mgmt_regs dut (.CLK_IN(clk), .NRST_IN(nrst), .REQ_IN(req),
    .REQ_WR_IN(wr), .REQ_IDX_IN(idx), .REQ_WDATA_IN(wd), .ACK_OUT(ack),
    .RDATA_OUT(rdat), .MODE_STRAP_IN(strap), .LINK_UP_IN(link),
    .JABBER_IN(jab), .REM_FAULT_IN(rflt), .AN_DONE_IN(andn),
    .ENERGY_IN(nrg), .SYM_ERR_IN(sym), .FAULT_IN(flt), .EVENT_IN(evt),
    .SOFT_RST_OUT(srst), .LOOPBACK_OUT(loopb), .SPEED_OUT(spd),
    .AN_EN_OUT(anen), .PWRDN_OUT(pdn), .ISOLATE_OUT(iso), .DUPLEX_OUT(dpx),
    .AN_RESTART_OUT(anrs), .FAR_LOOP_OUT(farl), .DIAG_READY_OUT(diag),
    .MODE_OUT(mode), .PHY_ADDR_OUT(phya), .TDR_PAT_OUT(tdr),
    .VENDOR_CTL_OUT(vctl));
  mrb_smc smc (.clk_in(clk), .ack_in(ack), .rdata_in(rdat), .req_out(req),
    .wr_out(wr), .idx_out(idx), .wdata_out(wd));
  task automatic chk(input mrb_word_t got, input mrb_word_t exp,
                     input string m);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wrr(input mrb_idx_t i, input mrb_word_t d);
    mrb_word_t r;
    logic ok;
    smc.xfer(1'b1, i, d, r, ok);
    chk({15'h0, ok}, 16'h0001, "write ack");
  endtask
  task automatic rdc(input mrb_idx_t i, input mrb_word_t e, input string m);
    mrb_word_t r;
    logic ok;
    smc.xfer(1'b0, i, 16'h0000, r, ok);
    chk({15'h0, ok}, 16'h0001, "read ack");
    chk(r, e, m);
  endtask
  task automatic pulse(input int n);
    repeat (n) @(negedge clk);
    {jab, link, flt, evt} = {1'b0, 1'b1, 4'h0, 8'h00};
    sym = 1'b0;
    andn = 1'b0;
  endtask
  task automatic t_ctrl;
    rdc(5'h00, 16'h3000, "strap defaults");
    chk({13'h0, spd, anen, dpx}, 16'h0006, "strap outputs");
    wrr(5'h00, 16'h4C00);
    rdc(5'h00, 16'h4C00, "control readback");
    chk({15'h0, loopb}, 16'h0001, "loopback out");
    chk({14'h0, pdn, iso}, 16'h0003, "power and isolate out");
    $display("test ctrl done");
  endtask
  task automatic t_status;
    @(negedge clk);
    {jab, link, rflt} = 3'b101;
    pulse(1);
    wrr(5'h01, 16'h0000);
    rdc(5'h01, 16'h7813, "latched status");
    rdc(5'h01, 16'h7815, "sticky held");
    rflt = 1'b0;
    rdc(5'h01, 16'h7815, "sticky until read");
    rdc(5'h01, 16'h7805, "sticky follows");
    $display("test status done");
  endtask
  task automatic t_clear;
    @(negedge clk);
    {flt, evt, sym} = {4'hF, 8'h5A, 1'b1};
    @(negedge clk);
    {flt, evt} = 12'h000;
    pulse(2);
    wrr(5'h1A, 16'hFFFF);
    rdc(5'h1A, 16'h0003, "symbol count");
    rdc(5'h1A, 16'h0000, "count cleared");
    rdc(5'h1D, 16'h005A, "events");
    rdc(5'h1D, 16'h0000, "events cleared");
    rdc(5'h1B, 16'h000F, "fault flags");
    wrr(5'h1B, 16'h0005);
    rdc(5'h1B, 16'h000A, "one clears");
    wrr(5'h1B, 16'h0000);
    rdc(5'h1B, 16'h000A, "zero keeps");
    rdc(5'h1C, 16'h0001, "fault count");
    wrr(5'h1C, 16'h00A5);
    rdc(5'h1C, 16'h0000, "any write clears");
    $display("test clear done");
  endtask
  task automatic t_self;
    wrr(5'h00, 16'h3200);
    chk({15'h0, anrs}, 16'h0001, "restart out");
    repeat (6) @(negedge clk);
    rdc(5'h00, 16'h3000, "restart cleared");
    wrr(5'h11, 16'h0200);
    chk({15'h0, diag}, 16'h0000, "ready out low");
    rdc(5'h11, 16'h0200, "ready low");
    chk({15'h0, farl}, 16'h0001, "far loop out");
    repeat (10) @(negedge clk);
    nrg = 1'b1;
    rdc(5'h11, 16'h0203, "ready set again");
    chk({15'h0, diag}, 16'h0001, "ready out high");
    $display("test self done");
  endtask
  task automatic t_soft;
    wrr(5'h12, 16'h0043);
    chk({8'h0, mode, phya}, 16'h0043, "mode outputs");
    wrr(5'h1F, 16'h007C);
    chk({11'h0, vctl}, 16'h001F, "vendor out");
    @(negedge clk);
    andn = 1'b1;
    pulse(1);
    rdc(5'h1F, 16'h107C, "seen flag");
    wrr(5'h1F, 16'h007C);
    rdc(5'h1F, 16'h007C, "seen cleared");
    wrr(5'h00, 16'h4000);
    wrr(5'h00, 16'h8000);
    chk({15'h0, srst}, 16'h0001, "soft reset out");
    repeat (4) @(negedge clk);
    rdc(5'h12, 16'h0043, "immune kept");
    rdc(5'h1F, 16'h0000, "vendor default");
    rdc(5'h00, 16'h3000, "control default");
    $display("test soft done");
  endtask
  task automatic t_mmd;
    wrr(5'h0D, 16'h0003);
    wrr(5'h0E, 16'h0005);
    wrr(5'h0D, 16'h4003);
    wrr(5'h0E, 16'hBEEF);
    rdc(5'h0E, 16'hBEEF, "extended data");
    wrr(5'h0D, 16'hC003);
    wrr(5'h0E, 16'h1111);
    wrr(5'h0E, 16'h2222);
    wrr(5'h0D, 16'h0003);
    wrr(5'h0E, 16'h0005);
    rdc(5'h0E, 16'h0005, "extended address");
    wrr(5'h0D, 16'h8003);
    rdc(5'h0E, 16'h1111, "post increment first");
    rdc(5'h0E, 16'h2222, "post increment next");
    wrr(5'h18, 16'h1234);
    chk(tdr, 16'h1234, "pattern out");
    wrr(5'h15, 16'hFFFF);
    rdc(5'h15, 16'h0000, "empty index");
    rdc(5'h02, 16'h0000, "empty low index");
    $display("test mmd done");
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    repeat (6) @(negedge clk);
    t_ctrl();
    t_status();
    t_clear();
    t_self();
    t_soft();
    t_mmd();
    summarize();
  end
endmodule
